// ### core/ptm_timebase.v
// Counter array timebase: source select, idle suspend, overflow interrupt
//
// Contract
// - Idle-suspend set halts counting while the CPU idles.
// - Idle-suspend clear keeps counting regardless of CPU idle.
// - Mode bits 6..4 read zero; writes to them ignored.
// - Select 000 sysclk/12, 001 sysclk/4, 010 timer0 overflow, 100 sysclk.
// - Select 011 counts falling edges of the external count input.
// - Select 101 counts external clock divided by 8, synchronised.
// - Overflow interrupt enable set requests interrupt while flag set.
// - Overflow interrupt enable clear gives no overflow request; irq still asserts on a wrap while irq_mask bit 0 is set.
// - Overflow flag is bit 7 of the control register.
//
// Implementation choice: the plain strobed port.
`timescale 1ns/100ps
`include "ptm_consts.vh"
module ptm_timebase #(
    parameter CNT_WIDTH = 16
) (
    mclk,
    reset,
    reg_addr,
    reg_wdata,
    reg_wr,
    reg_rd,
    reg_rdata,
    cpu_idle,
    timer0_overflow,
    external_count_input,
    ext_clock_in,
    count_pulse,
    counter_value,
    overflow_irq,
    irq
);
    input  wire                 mclk;
    input  wire                 reset;
    input  wire [7:0]           reg_addr;
    input  wire [7:0]           reg_wdata;
    input  wire                 reg_wr;
    input  wire                 reg_rd;
    output reg  [7:0]           reg_rdata;
    input  wire                 cpu_idle;
    input  wire                 timer0_overflow;
    input  wire                 external_count_input;
    input  wire                 ext_clock_in;
    output reg                  count_pulse;
    output reg  [CNT_WIDTH-1:0] counter_value;
    output wire                 overflow_irq;
    output wire                 irq;

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    reg  [7:0] counter_array_mode;
    reg        overflow_flag;
    reg        run_enable;
    reg  [1:0] irq_status;
    reg  [1:0] irq_mask;

    wire       idle_suspend        = counter_array_mode[`PTM_MODE_IDLE_BIT];
    wire [2:0] timebase_select     =
        counter_array_mode[`PTM_MODE_SEL_HI:`PTM_MODE_SEL_LO];
    wire       overflow_irq_enable = counter_array_mode[`PTM_MODE_IRQ_BIT];

    // ------------------------------------------------------------
    // Prescalers
    // ------------------------------------------------------------
    reg  [3:0] div12_cnt;
    reg  [1:0] div4_cnt;
    reg  [2:0] ext_div_cnt;
    reg        ext_div_out;
    wire       div12_tick = (div12_cnt == 4'd0);
    wire       div4_tick  = (div4_cnt == 2'd0);

    always @(posedge mclk) begin
        if (reset) begin
            div12_cnt <= 4'h0;
            div4_cnt  <= 2'h0;
        end else begin
            if (div12_cnt == 4'd`PTM_DIV_SLOW - 4'd1) begin
                div12_cnt <= 4'h0;
            end else begin
                div12_cnt <= div12_cnt + 4'd1;
            end
            div4_cnt <= div4_cnt + 2'd1;
        end
    end

    // Edge pulses from the pins; both pass two flops first
    wire eci_fall;
    wire ext_div_fall;

    ptm_ext_sync u_eci_sync (
        .mclk       (mclk),
        .reset      (reset),
        .async_in   (external_count_input),
        .fall_pulse (eci_fall)
    );

    // External clock divided by 8 in its own small ripple stage, then
    // synchronised; safe only while it is no faster than mclk.
    always @(posedge ext_clock_in) begin
        ext_div_cnt <= ext_div_cnt + 3'd1;
        ext_div_out <= ext_div_cnt[2];
    end

    ptm_ext_sync u_ext_sync (
        .mclk       (mclk),
        .reset      (reset),
        .async_in   (ext_div_out),
        .fall_pulse (ext_div_fall)
    );

    // ------------------------------------------------------------
    // Source select
    // ------------------------------------------------------------
    reg source_tick;
    always @* begin
        case (timebase_select)
            `PTM_SEL_DIV12:    source_tick = div12_tick;
            `PTM_SEL_DIV4:     source_tick = div4_tick;
            `PTM_SEL_TMR0:     source_tick = timer0_overflow;
            `PTM_SEL_EXT_EDGE: source_tick = eci_fall;
            `PTM_SEL_SYSCLK:   source_tick = 1'b1;
            `PTM_SEL_EXT_DIV8: source_tick = ext_div_fall;
            default:           source_tick = 1'b0;
        endcase
    end

    // Idle only gates when suspend is requested
    wire suspended  = idle_suspend & cpu_idle;
    wire next_pulse = run_enable & source_tick & ~suspended;
    wire wrap       = next_pulse & (&counter_value);

    // ------------------------------------------------------------
    // Counter and flag
    // ------------------------------------------------------------
    wire wr_mode  = reg_wr & (reg_addr == `PTM_ADDR_MODE);
    wire wr_ctrl  = reg_wr & (reg_addr == `PTM_ADDR_CONTROL);
    wire wr_lo    = reg_wr & (reg_addr == `PTM_ADDR_CNT_LO);
    wire wr_hi    = reg_wr & (reg_addr == `PTM_ADDR_CNT_HI);
    wire wr_stat  = reg_wr & (reg_addr == `PTM_ADDR_IRQ_STAT);
    wire wr_imask = reg_wr & (reg_addr == `PTM_ADDR_IRQ_MASK);

    always @(posedge mclk) begin
        if (reset) begin
            counter_array_mode <= `PTM_MODE_RESET;
            run_enable         <= 1'b0;
            overflow_flag      <= 1'b0;
            counter_value      <= {CNT_WIDTH{1'b0}};
            count_pulse        <= 1'b0;
            irq_status         <= 2'b00;
            irq_mask           <= 2'b00;
        end else begin
            count_pulse <= next_pulse;
            if (wr_mode) begin
                counter_array_mode <= reg_wdata & `PTM_MODE_WMASK;
            end
            if (wr_ctrl) begin
                run_enable <= reg_wdata[`PTM_CTRL_RUN_BIT];
            end
            // Hardware set wins over a software clear
            if (wrap) begin
                overflow_flag <= 1'b1;
            end else if (wr_ctrl) begin
                overflow_flag <= reg_wdata[`PTM_CTRL_OVF_BIT];
            end
            if (wr_lo) begin
                counter_value[7:0] <= reg_wdata;
            end else if (wr_hi) begin
                counter_value[CNT_WIDTH-1:8] <= reg_wdata[CNT_WIDTH-9:0];
            end else if (next_pulse) begin
                counter_value <= counter_value + {{(CNT_WIDTH-1){1'b0}}, 1'b1};
            end
            // Status: bit0 wrap event, bit1 external edge event
            irq_status[0] <= wrap | (irq_status[0] &
                             ~(wr_stat & reg_wdata[0]));
            irq_status[1] <= (eci_fall & ~suspended) | (irq_status[1] &
                             ~(wr_stat & reg_wdata[1]));
            if (wr_imask) begin
                irq_mask <= reg_wdata[1:0];
            end
        end
    end

    // Enable gates the flag onto the request line
    assign overflow_irq = overflow_flag & overflow_irq_enable;
    assign irq          = |(irq_status & irq_mask);

    // ------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------
    always @(posedge mclk) begin
        if (reset) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            case (reg_addr)
                `PTM_ADDR_MODE:      reg_rdata <= counter_array_mode;
                `PTM_ADDR_CONTROL:   reg_rdata <= {overflow_flag, run_enable,
                                                   6'h00};
                `PTM_ADDR_CNT_LO:    reg_rdata <= counter_value[7:0];
                `PTM_ADDR_CNT_HI:    reg_rdata <= counter_value[CNT_WIDTH-1 -: 8];
                `PTM_ADDR_IRQ_STAT:  reg_rdata <= {6'h00, irq_status};
                `PTM_ADDR_IRQ_MASK:  reg_rdata <= {6'h00, irq_mask};
                default:             reg_rdata <= 8'h00;
            endcase
        end else begin
            reg_rdata <= 8'h00;
        end
    end
endmodule // ptm_timebase

// ### core/ptm_consts.vh
// Constants for the counter array timebase mode control
`ifndef PTM_CONSTS_VH
`define PTM_CONSTS_VH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define PTM_ADDR_MODE      8'hD9
`define PTM_ADDR_CONTROL   8'hD8
`define PTM_ADDR_CNT_LO    8'hE9
`define PTM_ADDR_CNT_HI    8'hF9
`define PTM_ADDR_IRQ_STAT  8'hDA
`define PTM_ADDR_IRQ_MASK  8'hDB

// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define PTM_MODE_IDLE_BIT  7
`define PTM_MODE_SEL_HI    3
`define PTM_MODE_SEL_LO    1
`define PTM_MODE_IRQ_BIT   0
`define PTM_MODE_WMASK     8'h8F
`define PTM_MODE_RESET     8'h00
`define PTM_CTRL_OVF_BIT   7
`define PTM_CTRL_RUN_BIT   6
`define PTM_IRQ_MASK_RESET 8'h00

// ----------------------------------------------------------------
// Timebase select codes
// ----------------------------------------------------------------
`define PTM_SEL_DIV12      3'h0
`define PTM_SEL_DIV4       3'h1
`define PTM_SEL_TMR0       3'h2
`define PTM_SEL_EXT_EDGE   3'h3
`define PTM_SEL_SYSCLK     3'h4
`define PTM_SEL_EXT_DIV8   3'h5

// ----------------------------------------------------------------
// Divide ratios
// ----------------------------------------------------------------
`define PTM_DIV_SLOW       12
`define PTM_DIV_FAST       4
`define PTM_DIV_EXT        8

`endif

// ### core/ptm_ext_sync.v
// Two-flop synchroniser with falling-edge detector for external inputs
`timescale 1ns/100ps
module ptm_ext_sync (
    mclk,
    reset,
    async_in,
    fall_pulse
);
    input  wire mclk;
    input  wire reset;
    input  wire async_in;
    output reg  fall_pulse;

    reg meta;
    reg stable;
    reg stable_d;

    always @(posedge mclk) begin
        if (reset) begin
            meta       <= 1'b1;
            stable     <= 1'b1;
            stable_d   <= 1'b1;
            fall_pulse <= 1'b0;
        end else begin
            meta       <= async_in;
            stable     <= meta;
            stable_d   <= stable;
            fall_pulse <= stable_d & ~stable;
        end
    end
endmodule // ptm_ext_sync

// ### verif/ptm_timebase_asserts.sv
// Port-level property checker for the timebase mode control
`timescale 1ns/100ps
`include "ptm_consts.vh"
module ptm_timebase_chk #(parameter CNT_WIDTH = 16) (
    input logic                 mclk, reset, reg_wr, reg_rd,
    input logic [7:0]           reg_addr, reg_wdata, reg_rdata,
    input logic                 cpu_idle, timer0_overflow,
    input logic                 external_count_input, ext_clock_in,
    input logic                 count_pulse, overflow_irq, irq,
    input logic [CNT_WIDTH-1:0] counter_value
);
    // Shadow of mode and run bits, rebuilt from write traffic
    reg [7:0] mode;
    reg       run;
    always @(posedge mclk) begin
        if (reset) begin
            mode <= 8'h00;
            run  <= 1'b0;
        end else if (reg_wr && reg_addr == `PTM_ADDR_MODE) begin
            mode <= reg_wdata & `PTM_MODE_WMASK;
        end else if (reg_wr && reg_addr == `PTM_ADDR_CONTROL) begin
            run <= reg_wdata[`PTM_CTRL_RUN_BIT];
        end
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (reset);
    sequence wrap_s;
        counter_value == '0 && $past(counter_value) == '1 && !$past(reg_wr);
    endsequence
    sequence idle_s;
        mode[7] && cpu_idle && !reg_wr;
    endsequence
    a_unused_zero: assert property (
        reg_rd && reg_addr == `PTM_ADDR_MODE |=> reg_rdata[6:4] == 3'h0)
        else $error("Unused mode bits read nonzero");
    a_irq_disabled: assert property (
        !mode[0] |-> !overflow_irq) else $error("Masked overflow request");
    a_wrap_irq: assert property (
        wrap_s ##0 mode[0] |-> overflow_irq) else $error("Wrap without request");
    a_idle_freeze: assert property (
        idle_s |=> $stable(counter_value)) else $error("Counted while idle");
    a_sysclk_every: assert property (
        run && mode[3:1] == 3'h4 && !(mode[7] && cpu_idle) && !reg_wr
        |=> count_pulse) else $error("Missing system clock pulse");
    a_reserved_quiet: assert property (
        (mode[3:2] == 2'h3) [*2] |-> !count_pulse)
        else $error("Pulse on reserved select");
    a_pulse_step: assert property (
        count_pulse && !$past(reg_wr)
        |-> counter_value == $past(counter_value) + 1'b1)
        else $error("Pulse without single increment");
    a_div4_gap: assert property (
        count_pulse && mode[3:1] == 3'h1 |=> !count_pulse [*3])
        else $error("Divide by four pulses too close");
endmodule // ptm_timebase_chk
bind ptm_timebase ptm_timebase_chk #(.CNT_WIDTH(CNT_WIDTH)) ptm_chk_i (
    .mclk(mclk), .reset(reset), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .cpu_idle(cpu_idle), .timer0_overflow(timer0_overflow),
    .external_count_input(external_count_input),
    .ext_clock_in(ext_clock_in), .count_pulse(count_pulse),
    .overflow_irq(overflow_irq), .irq(irq), .counter_value(counter_value));

// ### verif/ptm_timebase_test.sv
// Self-checking bench for the timebase mode control
`timescale 1ns/100ps
`include "ptm_consts.vh"
module ptm_timebase_test;
    reg         mclk, reset, reg_wr, reg_rd, cpu_idle, timer0_overflow;
    reg         external_count_input, ext_clock_in;
    reg  [7:0]  reg_addr, reg_wdata;
    wire [7:0]  reg_rdata;
    wire [15:0] counter_value;
    wire        count_pulse, overflow_irq, irq;
    integer     failures, check_count, cycles, n, k;
    // Mode byte and pulses expected in a 240-cycle window, entry 0 first
    reg  [79:0] modes = 80'h020C00040608_0A0E8808;
    reg  [79:0] want  = 80'h3C0014281EF0_0F0000F0;
    ptm_timebase ptm_timebase_i (.mclk(mclk), .reset(reset),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cpu_idle(cpu_idle),
        .timer0_overflow(timer0_overflow),
        .external_count_input(external_count_input),
        .ext_clock_in(ext_clock_in), .count_pulse(count_pulse),
        .counter_value(counter_value), .overflow_irq(overflow_irq),
        .irq(irq));
    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end
    // Half the system clock rate, so the divided source stays legal
    initial begin
        ext_clock_in = 1'b0;
        #1.3;
        forever #4 ext_clock_in = ~ext_clock_in;
    end
    // Timer 0 pulse every 6 cycles, pin fall every 8 cycles
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        timer0_overflow <= (cycles % 6 == 5);
        external_count_input <= (cycles % 8 < 4);
        if (cycles == 10000) begin
            failures = failures + 1;
            end_of_test;
        end
    end
    task check(input [15:0] seen, input [15:0] exp);
        begin
            check_count = check_count + 1;
            if (seen !== exp) begin
                failures = failures + 1;
                $display("Error at %0t: seen %h expected %h", $time, seen, exp);
            end
        end
    endtask
    task wr(input [7:0] a, input [7:0] d);
        begin
            @(posedge mclk);
            reg_addr <= a;
            reg_wdata <= d;
            reg_wr <= 1'b1;
            @(posedge mclk);
            reg_wr <= 1'b0;
        end
    endtask
    task rd(input [7:0] a, input [7:0] exp);
        begin
            @(posedge mclk);
            reg_addr <= a;
            reg_rd <= 1'b1;
            @(posedge mclk);
            reg_rd <= 1'b0;
            #1 check({8'h00, reg_rdata}, {8'h00, exp});
        end
    endtask
    task end_of_test;
        begin
            $display("Checks %0d, mismatches %0d", check_count, failures);
            if (failures == 0 && check_count > 0)
                $display("SIMULATION PASSED");
            else
                $display("SIMULATION FAILED");
            $finish;
        end
    endtask
    initial begin
        failures = 0;
        check_count = 0;
        cycles = 0;
        reset = 1'b1;
        {reg_wr, reg_rd, cpu_idle, timer0_overflow} = 4'h0;
        {reg_addr, reg_wdata} = 16'h0000;
        external_count_input = 1'b1;
        repeat (5) @(posedge mclk);
        reset <= 1'b0;
        rd(`PTM_ADDR_MODE, `PTM_MODE_RESET);
        rd(`PTM_ADDR_CONTROL, 8'h00);
        wr(`PTM_ADDR_MODE, 8'hFF);
        rd(`PTM_ADDR_MODE, 8'h8F);
        wr(8'h10, 8'hFF);
        rd(8'h10, 8'h00);
        wr(`PTM_ADDR_CONTROL, 8'h40);
        for (k = 0; k < 10; k = k + 1) begin
            cpu_idle <= (k > 7);
            wr(`PTM_ADDR_MODE, modes[(9 - k) * 8 +: 8]);
            repeat (24) @(posedge mclk);
            n = 0;
            repeat (240) @(negedge mclk) n = n + (count_pulse === 1'b1);
            check(n[15:0], {8'h00, want[(9 - k) * 8 +: 8]});
        end
        cpu_idle <= 1'b0;
        wr(`PTM_ADDR_CONTROL, 8'h00);
        wr(`PTM_ADDR_CNT_LO, 8'hFE);
        wr(`PTM_ADDR_CNT_HI, 8'hFF);
        wr(`PTM_ADDR_IRQ_MASK, 8'h01);
        wr(`PTM_ADDR_MODE, 8'h09);
        #1 check({14'h0, overflow_irq, irq}, 16'h0000);
        wr(`PTM_ADDR_CONTROL, 8'h40);
        repeat (6) @(posedge mclk);
        #1 check({14'h0, overflow_irq, irq}, 16'h0003);
        rd(`PTM_ADDR_CONTROL, 8'hC0);
        wr(`PTM_ADDR_MODE, 8'h08);
        #1 check({14'h0, overflow_irq, irq}, 16'h0001);
        wr(`PTM_ADDR_IRQ_MASK, 8'h00);
        #1 check({15'h0, irq}, 16'h0000);
        wr(`PTM_ADDR_IRQ_MASK, 8'h01);
        #1 check({15'h0, irq}, 16'h0001);
        wr(`PTM_ADDR_IRQ_STAT, 8'h01);
        #1 check({15'h0, irq}, 16'h0000);
        wr(`PTM_ADDR_CONTROL, 8'h00);
        end_of_test;
    end
endmodule // ptm_timebase_test
